/* File: btc_pkg.sv */
// Purpose: Shared constants for the branch trace control block.
// Assumes: 32-bit register bus, register index times four is the address.
// Notes:   Word offsets are indices; byte address is four times the index.
package btc_pkg;
  localparam int            AW          = 14;
  localparam logic [11:0]   IDX_STACK_LO = 12'h0040;
  localparam logic [11:0]   IDX_STACK_HI = 12'h0048;
  localparam logic [11:0]   IDX_TOS      = 12'h01c9;
  localparam logic [11:0]   IDX_CTL      = 12'h01d9;
  localparam logic [11:0]   IDX_LER_TO   = 12'h01dd;
  localparam logic [11:0]   IDX_LER_FROM = 12'h01de;
  localparam logic [11:0]   IDX_BUF_IDX  = 12'h0300;
  localparam logic [11:0]   IDX_BUF_MAX  = 12'h0301;
  localparam logic [11:0]   IDX_BUF_THR  = 12'h0302;
  localparam logic [11:0]   IDX_STATUS   = 12'h0303;
  localparam int            CTL_W       = 11;
  localparam int            B_REC       = 0;
  localparam int            B_STEP      = 1;
  localparam int            B_PIN       = 2;
  localparam int            B_MSG       = 6;
  localparam int            B_STORE     = 7;
  localparam int            B_SIRQ      = 8;
  localparam int            B_SKIP_K    = 9;
  localparam int            B_SKIP_U    = 10;
  localparam int            ST_STORE    = 0;
  localparam int            ST_PMI_MASK = 1;
  localparam logic [10:0]   CTL_RESET   = 11'h000;
  localparam logic [31:0]   BUF_MAX_RST = 32'h0000_00ff;
  localparam logic [31:0]   BUF_THR_RST = 32'h0000_00f0;
  localparam logic [1:0]    RESP_OKAY   = 2'h0;
  localparam logic [1:0]    RESP_SLVERR = 2'h2;
  localparam int            STACK_N     = 8;
  localparam int            TOS_W       = 3;
endpackage : btc_pkg

/* File: btc_stack.sv */
// Purpose: Last-branch stack, newest pointer and last-exception pair.
// Assumes: One record per cycle at most.
// Notes:   Read port is combinational; the parent registers it.
`timescale 1ns/1ps
module btc_stack
  import btc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              rec_en,
  input  wire logic              ev_valid,
  input  wire logic              ev_is_exc,
  input  wire logic [31:0]       ev_from,
  input  wire logic [31:0]       ev_to,
  input  wire logic [TOS_W-1:0]  rd_sel,
  output logic      [31:0]       rd_from,
  output logic      [31:0]       rd_to,
  output logic      [TOS_W-1:0]  newest_record_pointer,
  output logic      [31:0]       ler_from,
  output logic      [31:0]       ler_to
);
  logic [63:0]      stack_r [STACK_N];
  logic [TOS_W-1:0] tos_r;
  logic [31:0]      ler_from_r;
  logic [31:0]      ler_to_r;
  logic [TOS_W-1:0] tos_nxt;

  assign tos_nxt  = tos_r + 3'h1;
  assign newest_record_pointer      = tos_r;
  assign rd_from  = stack_r[rd_sel][31:0];
  assign rd_to    = stack_r[rd_sel][63:32];
  assign ler_from = ler_from_r;
  assign ler_to   = ler_to_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tos_r <= '0;
      for (int i = 0; i < STACK_N; i++) stack_r[i] <= '0;
    end else if (rec_en && ev_valid) begin
      tos_r <= tos_nxt;
      stack_r[tos_nxt] <= {ev_to, ev_from};
    end
  end

  // The previous newest entry is copied before it can be overwritten.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ler_from_r <= '0;
      ler_to_r   <= '0;
    end else if (rec_en && ev_valid && ev_is_exc) begin
      ler_from_r <= stack_r[tos_r][31:0];
      ler_to_r   <= stack_r[tos_r][63:32];
    end
  end

  a_tos_advance: assert property (@(posedge aclk) disable iff (!aresetn)
    rec_en && ev_valid |=> tos_r == $past(tos_r) + 3'h1)
    else $error("Newest pointer did not advance.");
  a_entry_write: assert property (@(posedge aclk) disable iff (!aresetn)
    rec_en && ev_valid |=> stack_r[tos_r] == {$past(ev_to), $past(ev_from)})
    else $error("Stack entry not written at pointer.");
  a_ler_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    rec_en && ev_valid && ev_is_exc
    |=> {ler_to_r, ler_from_r} == stack_r[$past(tos_r)])
    else $error("Last exception pair not captured.");
endmodule : btc_stack

/* File: btc_top.sv */
// Function
// - No messages while message enable clear.
// - Store clear sends on bus, set logs.
// - Never bus and buffer at once.
// - Interrupt flag clear makes buffer circular.
// - Interrupt flag set raises nearly-full interrupt.
// - Skip-kernel stores only privilege above zero.
// - Skip-user stores only privilege zero.
// - Both skips: message generated, nothing stored.
// - Interrupt when index reaches threshold.
// - All trace sources share one interrupt.
// - Full non-circular buffer keeps store setting.
// - Taken interrupt masks; software clears mask.
// - Record bit keeps last-branch stack running.
// - Step bit steps on control transfers.
// - Selected pin pulses on address match.
// - Unselected pin reports performance events.
// - Message enable bit six emits messages.
// - Bits seven, eight: store and interrupt.
// - Eight entries, source low, target high.
// - Three-bit pointer selects newest entry.
// - Exception pair keeps branch before exception.
//
// Purpose: Branch trace control with register slave on AXI4-Lite.
// Assumes: Event inputs are one-cycle pulses synchronous to aclk.
// Notes:   Buffer writes are requests; a memory writer performs them.
`timescale 1ns/1ps
module btc_top
  import btc_pkg::*;
#(
  parameter int  IW        = 32,
  parameter bit  PRIV_FILT = 1'b1
)(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          wvalid,
  output logic               wready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  output logic               bvalid,
  input  wire logic          bready,
  output logic [1:0]         bresp,
  input  wire logic          arvalid,
  output logic               arready,
  input  wire logic [AW-1:0] araddr,
  output logic               rvalid,
  input  wire logic          rready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  input  wire logic          ev_valid,
  input  wire logic          ev_is_exc,
  input  wire logic [31:0]   ev_from,
  input  wire logic [31:0]   ev_to,
  input  wire logic [1:0]    privilege_level,
  input  wire logic          trap_flag,
  input  wire logic [3:0]    bp_match,
  input  wire logic [3:0]    perf_event,
  input  wire logic          nonprecise_ovf,
  input  wire logic          precise_ovf,
  input  wire logic          irq_taken,
  output logic               msg_valid,
  output logic [31:0]        msg_from,
  output logic [31:0]        msg_to,
  output logic               store_valid,
  output logic [IW-1:0]      store_slot,
  output logic [31:0]        store_from,
  output logic [31:0]        store_to,
  output logic               trace_irq,
  output logic               step_exc,
  output logic [3:0]         breakpoint_pin_n
);
  logic [CTL_W-1:0] ctl_r;
  logic [IW-1:0]    idx_r;
  logic [IW-1:0]    max_r;
  logic [IW-1:0]    thr_r;
  logic [1:0]       st_r;
  logic             aw_have_r;
  logic             w_have_r;
  logic [11:0]      aw_idx_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic             go_bus;
  logic             go_store;
  logic             do_wr;
  logic             full;
  logic [11:0]      ar_idx;
  logic [2:0]       rd_sel;
  logic [31:0]      sk_from;
  logic [31:0]      sk_to;
  logic [2:0]       newest_record_pointer;
  logic [31:0]      ler_from;
  logic [31:0]      ler_to;
  logic [31:0]      rd_nxt;
  logic             rd_ok;
  logic             thr_hit;
  logic [31:0]      ctl_wr;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction : merge

  function automatic logic [11:0] word_idx(input logic [AW-1:0] a);
    return a[AW-1:2];
  endfunction : word_idx

  // Write channel: address and data are latched independently.
  assign awready = !aw_have_r && !bvalid;
  assign wready  = !w_have_r && !bvalid;
  assign do_wr   = aw_have_r && w_have_r && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_idx_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have_r <= 1'b1;
        aw_idx_r  <= word_idx(awaddr);
      end
      if (wvalid && wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
      if (do_wr) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= (aw_idx_r == IDX_CTL || aw_idx_r == IDX_BUF_IDX ||
                      aw_idx_r == IDX_BUF_MAX || aw_idx_r == IDX_BUF_THR ||
                      aw_idx_r == IDX_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Message routing decision for the current event.
  always_comb begin
    go_bus   = 1'b0;
    go_store = 1'b0;
    if (ev_valid && ctl_r[B_MSG]) begin
      if (!ctl_r[B_STORE]) begin
        go_bus = 1'b1;
      end else if (ctl_r[B_SKIP_K] && ctl_r[B_SKIP_U]) begin
        go_bus = 1'b1;
      end else if (ctl_r[B_SKIP_K] && privilege_level == 2'h0) begin
        go_store = 1'b0;
      end else if (ctl_r[B_SKIP_U] && privilege_level != 2'h0) begin
        go_store = 1'b0;
      end else begin
        go_store = 1'b1;
      end
    end
  end

  assign ctl_wr = merge({21'h0, ctl_r}, wdata_r, wstrb_r);

  // Control register; a step exception retires the step bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= CTL_RESET;
    end else if (do_wr && aw_idx_r == IDX_CTL) begin
      ctl_r <= ctl_wr[CTL_W-1:0]
               & {PRIV_FILT, PRIV_FILT, 9'h1ff};
    end else if (ev_valid && trap_flag && ctl_r[B_STEP]) begin
      ctl_r[B_STEP] <= 1'b0;
    end
  end

  assign full    = idx_r >= max_r;
  assign thr_hit = idx_r >= thr_r;

  // Buffer index: software writes win, which is how the handler rewinds it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_r       <= '0;
      max_r       <= IW'(BUF_MAX_RST);
      thr_r       <= IW'(BUF_THR_RST);
      store_valid <= 1'b0;
      store_slot  <= '0;
      store_from  <= '0;
      store_to    <= '0;
    end else begin
      store_valid <= 1'b0;
      if (do_wr && aw_idx_r == IDX_BUF_MAX)
        max_r <= IW'(merge(32'(max_r), wdata_r, wstrb_r));
      if (do_wr && aw_idx_r == IDX_BUF_THR)
        thr_r <= IW'(merge(32'(thr_r), wdata_r, wstrb_r));
      if (do_wr && aw_idx_r == IDX_BUF_IDX) begin
        idx_r <= IW'(merge(32'(idx_r), wdata_r, wstrb_r));
      end else if (go_store) begin
        store_from <= ev_from;
        store_to   <= ev_to;
        if (!full) begin
          store_valid <= 1'b1;
          store_slot  <= idx_r;
          idx_r       <= idx_r + IW'(1);
        end else if (!ctl_r[B_SIRQ]) begin
          store_valid <= 1'b1;
          store_slot  <= '0;
          idx_r       <= IW'(1);
        end
        // A full buffer without wrap drops the record; store stays on.
      end
    end
  end

  // Bus message output, never together with a buffer write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msg_valid <= 1'b0;
      msg_from  <= '0;
      msg_to    <= '0;
    end else begin
      msg_valid <= go_bus;
      if (go_bus) begin
        msg_from <= ev_from;
        msg_to   <= ev_to;
      end
    end
  end

  // Status: sticky store interrupt and mask, write one to clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= '0;
      trace_irq <= 1'b0;
    end else begin
      for (int b = 0; b < 2; b++)
        if (do_wr && aw_idx_r == IDX_STATUS && wstrb_r[0] && wdata_r[b])
          st_r[b] <= 1'b0;
      if (ctl_r[B_MSG] && ctl_r[B_STORE] && ctl_r[B_SIRQ] && thr_hit)
        st_r[ST_STORE] <= 1'b1;
      if (irq_taken)
        st_r[ST_PMI_MASK] <= 1'b1;
      trace_irq <= (st_r[ST_STORE] || nonprecise_ovf || precise_ovf)
                   && !st_r[ST_PMI_MASK];
    end
  end

  // Step exception and breakpoint pins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_exc         <= 1'b0;
      breakpoint_pin_n <= 4'hf;
    end else begin
      step_exc <= ev_valid && trap_flag && ctl_r[B_STEP];
      for (int p = 0; p < 4; p++)
        if (ctl_r[B_PIN+p])
          breakpoint_pin_n[p] <= !(bp_match[p] && breakpoint_pin_n[p]);
        else
          breakpoint_pin_n[p] <= !perf_event[p];
    end
  end
  // The pulse rule above re-arms after one cycle high; a held match blinks.

  // Stack keeps running while the record bit or message enable is set.
  btc_stack u_stack (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .rec_en   (ctl_r[B_REC] || ctl_r[B_MSG]),
    .ev_valid (ev_valid),
    .ev_is_exc(ev_is_exc),
    .ev_from  (ev_from),
    .ev_to    (ev_to),
    .rd_sel   (rd_sel),
    .rd_from  (sk_from),
    .rd_to    (sk_to),
    .newest_record_pointer      (newest_record_pointer),
    .ler_from (ler_from),
    .ler_to   (ler_to)
  );

  // Read channel: one word per request, answered the cycle after.
  assign ar_idx  = word_idx(araddr);
  assign rd_sel  = ar_idx[2:0];
  assign arready = !rvalid;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (ar_idx[11:3] == IDX_STACK_LO[11:3]) rd_nxt = sk_from;
    else if (ar_idx[11:3] == IDX_STACK_HI[11:3]) rd_nxt = sk_to;
    else if (ar_idx == IDX_TOS) rd_nxt = {29'h0, newest_record_pointer};
    else if (ar_idx == IDX_CTL) rd_nxt = {21'h0, ctl_r};
    else if (ar_idx == IDX_LER_TO) rd_nxt = ler_to;
    else if (ar_idx == IDX_LER_FROM) rd_nxt = ler_from;
    else if (ar_idx == IDX_BUF_IDX) rd_nxt = 32'(idx_r);
    else if (ar_idx == IDX_BUF_MAX) rd_nxt = 32'(max_r);
    else if (ar_idx == IDX_BUF_THR) rd_nxt = 32'(thr_r);
    else if (ar_idx == IDX_STATUS) rd_nxt = {30'h0, st_r};
    else rd_ok = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_nxt;
      rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  a_msg_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl_r[B_MSG] |=> !msg_valid && !store_valid)
    else $error("Trace output with messages disabled.");
  a_not_both: assert property (@(posedge aclk) disable iff (!aresetn)
    !(msg_valid && store_valid))
    else $error("Message sent and stored together.");
  a_bus_route: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_valid && ctl_r[B_MSG] && !ctl_r[B_STORE]
    |=> msg_valid && msg_from == $past(ev_from))
    else $error("Bus message missing.");
  a_circ_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    go_store && full && !ctl_r[B_SIRQ] && !do_wr
    |=> store_valid && store_slot == '0 && idx_r == IW'(1))
    else $error("Circular buffer did not wrap.");
  a_skip_user: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_valid && ctl_r[B_SKIP_U] && privilege_level != 2'h0
    |=> !store_valid)
    else $error("User-level record stored.");
  a_skip_kern: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_valid && ctl_r[B_SKIP_K] && privilege_level == 2'h0
    |=> !store_valid)
    else $error("Kernel-level record stored.");
  a_skip_both: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_valid && ctl_r[B_MSG] && ctl_r[B_STORE] && ctl_r[B_SKIP_K] &&
    ctl_r[B_SKIP_U] |=> msg_valid && !store_valid)
    else $error("Both skips did not route to bus.");
  a_thresh_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_r[B_MSG] && ctl_r[B_STORE] && ctl_r[B_SIRQ] && thr_hit &&
    !st_r[ST_PMI_MASK] && !irq_taken |=> ##1 trace_irq)
    else $error("Threshold interrupt not raised.");
  a_pmi_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_taken |=> st_r[ST_PMI_MASK] ##1 !trace_irq)
    else $error("Interrupt not masked after being taken.");
  a_step_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_valid && trap_flag && ctl_r[B_STEP] |=> step_exc && !ctl_r[B_STEP])
    else $error("Branch step exception missing.");
  a_pin_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_r[B_PIN] && bp_match[0] && breakpoint_pin_n[0] && !do_wr
    |=> !breakpoint_pin_n[0] ##1 breakpoint_pin_n[0] || !ctl_r[B_PIN])
    else $error("Breakpoint pin did not pulse.");
  a_perf_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl_r[B_PIN+1] && !do_wr |=> breakpoint_pin_n[1] == !$past(perf_event[1]))
    else $error("Pin does not follow performance event.");

  c_bus_msg: cover property (@(posedge aclk) disable iff (!aresetn)
    msg_valid);
  c_wrap: cover property (@(posedge aclk) disable iff (!aresetn)
    store_valid && store_slot == '0 ##1 store_valid);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn)
    trace_irq ##1 irq_taken);
endmodule : btc_top

/* File: btc_partner.sv */
// Purpose: Far side model: trace bus monitor and handler entry.
// Assumes: trace_irq is a level, serviced once per rise.
// Notes:   The bench finishes the handler through the registers.
`timescale 1ns/1ps
module btc_partner (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic msg_valid,
  input  wire logic trace_irq,
  output logic      irq_taken,
  output int        msg_cnt,
  output int        irq_cnt
);
  logic irq_r;
  // Acknowledge on the rise only, so a held level is not taken twice.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r     <= 1'b0;
      irq_taken <= 1'b0;
      irq_cnt   <= 0;
    end else begin
      irq_r     <= trace_irq;
      irq_taken <= trace_irq & ~irq_r;
      irq_cnt   <= irq_cnt + int'(trace_irq & ~irq_r);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msg_cnt <= 0;
    end else begin
      msg_cnt <= msg_cnt + int'(msg_valid);
    end
  end
endmodule : btc_partner

/* File: branch_trace_control_tb.sv */
// Purpose: Self-checking bench for the branch trace control block.
// Assumes: Register index times four is the bus address.
// Notes:   A shadow of the control word predicts stack recording.
`timescale 1ns/1ps
module branch_trace_control_tb;
  import btc_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, ev_valid = 0, ev_is_exc = 0;
  logic trap_flag = 0, np_ovf = 0, p_ovf = 0;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0]   wdata = '0, ev_from = '0, ev_to = '0, rd;
  logic [3:0]    bp_match = '0, perf_event = '0, pin_n;
  logic [1:0]    privilege_level = '0, bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, msg_valid, store_valid;
  logic trace_irq, step_exc, irq_taken;
  logic [31:0]   rdata, msg_from, msg_to, store_slot, store_from, store_to;
  logic [10:0]   ctl_sh = '0;
  logic [2:0]    o, tp;
  int msg_cnt, irq_cnt, err_total = 0, samples_checked = 0, n_rec = 0;
  logic [10:0]   pc [6] = '{11'h2c0, 11'h2c0, 11'h4c0, 11'h4c0, 11'h6c0,
                            11'h6c0};
  logic [1:0]    pp [6] = '{2'h0, 2'h3, 2'h0, 2'h2, 2'h0, 2'h1};
  logic [2:0]    po [6] = '{3'h0, 3'h2, 3'h2, 3'h0, 3'h1, 3'h1};

  always #25 aclk = ~aclk;

  btc_top btc_top_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .ev_valid(ev_valid), .ev_is_exc(ev_is_exc), .ev_from(ev_from),
    .ev_to(ev_to), .privilege_level(privilege_level), .trap_flag(trap_flag),
    .bp_match(bp_match), .perf_event(perf_event), .nonprecise_ovf(np_ovf),
    .precise_ovf(p_ovf), .irq_taken(irq_taken), .msg_valid(msg_valid),
    .msg_from(msg_from), .msg_to(msg_to), .store_valid(store_valid),
    .store_slot(store_slot), .store_from(store_from), .store_to(store_to),
    .trace_irq(trace_irq), .step_exc(step_exc), .breakpoint_pin_n(pin_n));
  btc_partner btc_partner_inst (.aclk(aclk), .aresetn(aresetn),
    .msg_valid(msg_valid), .trace_irq(trace_irq), .irq_taken(irq_taken),
    .msg_cnt(msg_cnt), .irq_cnt(irq_cnt));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    bit a, w;
    int t;
    a = 0;
    w = 0;
    t = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    // Address and data may be taken at different edges.
    while (!(a && w) && t < 100) begin
      @(posedge aclk);
      t++;
      if (awready && !a) begin
        awvalid <= 0;
        a = 1;
      end
      if (wready && !w) begin
        wvalid <= 0;
        w = 1;
      end
    end
    while (!bvalid && t < 200) begin
      @(posedge aclk);
      t++;
    end
    if (!bvalid) err_total++;
    rs = bresp;
    bready <= 0;
    if (idx == IDX_CTL && bresp === RESP_OKAY) ctl_sh = d[10:0];
  endtask : wr

  task automatic rdr(input logic [11:0] idx);
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      t++;
    end while (!arready && t < 100);
    arvalid <= 0;
    do begin
      @(posedge aclk);
      t++;
    end while (!rvalid && t < 200);
    if (!rvalid) err_total++;
    rd = rdata;
    rs = rresp;
    rready <= 0;
  endtask : rdr

  task automatic ev(input logic [31:0] f, input logic [31:0] t,
                    input logic [1:0] pl, input logic x);
    @(posedge aclk);
    ev_valid <= 1;
    ev_from <= f;
    ev_to <= t;
    privilege_level <= pl;
    ev_is_exc <= x;
    @(posedge aclk);
    ev_valid <= 0;
    #1;
    o = {step_exc, store_valid, msg_valid};
    if (ctl_sh[B_REC] || ctl_sh[B_MSG]) n_rec++;
  endtask : ev

  task automatic results;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    results();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rdr(IDX_CTL); chk(rd, 32'h0000_0000);
    rdr(IDX_BUF_MAX); chk(rd, BUF_MAX_RST);
    rdr(IDX_BUF_THR); chk(rd, BUF_THR_RST);
    rdr(IDX_TOS); chk(rd, 32'h0000_0000);
    wr(IDX_TOS, 32'h0000_0005); chk(rs, RESP_SLVERR);
    rdr(12'h100); chk(rs, RESP_SLVERR);
    wr(IDX_CTL, 32'h0000_0780);
    ev(32'h0000_0011, 32'h0000_0022, 2'h3, 0); chk(o, 3'h0);
    wr(IDX_CTL, 32'h0000_0040);
    ev(32'h0000_0033, 32'h0000_0044, 2'h3, 0); chk(o, 3'h1);
    chk({msg_from[15:0], msg_to[15:0]}, 32'h0033_0044);
    @(posedge aclk) #1 chk(msg_cnt, 1);
    // Circular buffer of two slots: third record wraps to slot zero.
    wr(IDX_BUF_MAX, 32'h0000_0002);
    wr(IDX_BUF_IDX, 32'h0000_0000);
    wr(IDX_CTL, 32'h0000_00c0);
    for (int i = 0; i < 3; i++) begin
      ev(32'h0000_0050 + i, 32'h0000_0060, 2'h0, 0);
      chk(o, 3'h2);
      chk(store_slot, (i == 1) ? 32'h1 : 32'h0);
      chk(store_from, 32'h0000_0050 + i);
      chk(store_to, 32'h0000_0060);
    end
    rdr(IDX_BUF_IDX); chk(rd, 32'h0000_0001);
    // Threshold interrupt, then a full buffer that drops records.
    wr(IDX_BUF_MAX, 32'h0000_0003);
    wr(IDX_BUF_THR, 32'h0000_0002);
    wr(IDX_BUF_IDX, 32'h0000_0000);
    wr(IDX_CTL, 32'h0000_01c0);
    for (int i = 0; i < 4; i++) begin
      ev(32'h0000_0070, 32'h0000_0080, 2'h0, 0);
      chk(o, (i < 3) ? 3'h2 : 3'h0);
    end
    repeat (4) @(posedge aclk);
    chk(irq_cnt, 1);
    rdr(IDX_STATUS); chk(rd, 32'h0000_0003);
    chk(trace_irq, 1'b0);
    rdr(IDX_CTL); chk(rd, 32'h0000_01c0);
    wr(IDX_CTL, 32'h0000_0000);
    wr(IDX_BUF_IDX, 32'h0000_0000);
    wr(IDX_STATUS, 32'h0000_0003);
    wr(IDX_CTL, 32'h0000_01c0);
    rdr(IDX_STATUS); chk(rd, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      {p_ovf, np_ovf} <= 2'h1 << k;
      repeat (4) @(posedge aclk);
      chk(irq_cnt, 2 + k);
      {p_ovf, np_ovf} <= 2'h0;
      wr(IDX_STATUS, 32'h0000_0003);
    end
    wr(IDX_BUF_MAX, 32'h0000_00ff);
    for (int i = 0; i < 6; i++) begin
      wr(IDX_CTL, {21'h0, pc[i]});
      ev(32'h0000_0090, 32'h0000_00a0, pp[i], 0);
      chk(o, po[i]);
    end
    wr(IDX_CTL, 32'h0000_0001);
    for (int i = 0; i < 9; i++) begin
      ev(32'h0000_0100 + i, 32'h0000_2000 + i, 2'h0, 0);
    end
    tp = n_rec[2:0];
    rdr(IDX_TOS); chk(rd, {29'h0, tp});
    rdr(IDX_STACK_LO + tp); chk(rd, 32'h0000_0108);
    rdr(IDX_STACK_HI + tp); chk(rd, 32'h0000_2008);
    rdr(IDX_STACK_LO + 12'(tp - 3'h1)); chk(rd, 32'h0000_0107);
    ev(32'h0000_0300, 32'h0000_0301, 2'h0, 1);
    rdr(IDX_LER_FROM); chk(rd, 32'h0000_0108);
    rdr(IDX_LER_TO); chk(rd, 32'h0000_2008);
    wr(IDX_CTL, 32'h0000_0003);
    trap_flag <= 1;
    ev(32'h0000_0400, 32'h0000_0401, 2'h0, 0); chk(o, 3'h4);
    trap_flag <= 0;
    rdr(IDX_CTL); chk(rd, 32'h0000_0001);
    wr(IDX_CTL, 32'h0000_0004);
    @(posedge aclk);
    bp_match <= 4'h1;
    perf_event <= 4'h3;
    @(posedge aclk);
    bp_match <= 4'h0;
    #1 chk(pin_n, 4'hc);
    @(posedge aclk);
    #1 chk(pin_n, 4'hd);
    results();
  end
endmodule : branch_trace_control_tb
